// ==== core/psc_pkg.sv ====
// Shared constants and types of the passive serial configuration loader
package psc_pkg;

   // System clock
   localparam int CLK_PERIOD_NS = 8;

   // Power-on reset delay, held on the status line before release
   localparam int POR_DELAY_US = 100;
   localparam int POR_CYCLES   =
      (POR_DELAY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Time spent initialising before user mode
   localparam int INIT_TIME_US = 10;
   localparam int INIT_CYCLES  =
      (INIT_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Bitstream layout
   localparam int CFG_BITS_DEF = 1024;
   localparam int OPT_BIT_POS  = 16;
   localparam int WORD_W_DEF   = 8;

   // Falling edges after the last bit: one closes the last bit period,
   // two more start initialisation
   localparam logic [1:0] FE_LAST = 2'h3;

   // Word buffer towards the system side
   localparam int BUF_DEPTH = 2;

   // Reload value of the system-domain timer
   localparam logic [31:0] TMR_RST = 32'h0;

   typedef enum logic [2:0] {
      ST_POR    = 3'h0,
      ST_CLEAR  = 3'h1,
      ST_LOAD   = 3'h2,
      ST_WAITFE = 3'h3,
      ST_INIT   = 3'h4,
      ST_USER   = 3'h5,
      ST_ERR    = 3'h6
   } psc_state_e;

endpackage : psc_pkg

// ==== core/psc_buf2.sv ====
// Small word buffer with valid and ready on both sides
module psc_buf2 #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 2
) (
   // Clock and reset
   input  wire logic             clk_sys,
   input  wire logic             rst_n,
   input  wire logic             flush,
   // Filling side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // Draining side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [PW-1:0]               wr;
      logic [PW-1:0]               rd;
      logic [CW-1:0]               cnt;
   } psc_buf_s;

   psc_buf_s buf_r;
   psc_buf_s buf_nxt;
   logic     push;
   logic     pop;

   function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
      ptr_inc = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
   endfunction : ptr_inc

   assign in_ready  = (buf_r.cnt != CW'(DEPTH));
   assign out_valid = (buf_r.cnt != '0);
   assign out_data  = buf_r.mem[buf_r.rd];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   always_comb begin
      buf_nxt = buf_r;
      if (push) begin
         buf_nxt.mem[buf_r.wr] = in_data;
         buf_nxt.wr            = ptr_inc(buf_r.wr);
      end
      if (pop) begin
         buf_nxt.rd = ptr_inc(buf_r.rd);
      end
      if (push && !pop) begin
         buf_nxt.cnt = buf_r.cnt + 1'b1;
      end else if (pop && !push) begin
         buf_nxt.cnt = buf_r.cnt - 1'b1;
      end
      if (flush) begin
         buf_nxt = '0;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         buf_r <= '0;
      end else begin
         buf_r <= buf_nxt;
      end
   end

endmodule : psc_buf2

// ==== core/psc_loader.sv ====
// Passive serial configuration port: pin sequencing and bit loading
//
// What this block does
// - In user mode the request, status and done lines all stand high.
// - A low request line starts a reconfiguration from any state but the power-on delay.
// - After power-up the status line is held low for the reset delay.
// - The done line stays low from power-up until loading finishes.
// - After configuration the data pin is a user pin per its setting.
// - Done is released only after every bit arrived without error.
// - Once its option bit is loaded, init-done is held low until user mode or a load error.
module psc_loader
   import psc_pkg::*;
#(
   parameter int POR_CYC  = psc_pkg::POR_CYCLES,
   parameter int INIT_CYC = psc_pkg::INIT_CYCLES,
   parameter int CFG_BITS = psc_pkg::CFG_BITS_DEF,
   parameter int OPT_BIT  = psc_pkg::OPT_BIT_POS,
   parameter int WORD_W   = psc_pkg::WORD_W_DEF
) (
   // System clock and reset
   input  wire logic              clk_sys,
   input  wire logic              rst_n,
   // Serial link from the host
   input  wire logic              serial_config_clock,
   input  wire logic              serial_config_data,
   input  wire logic              config_request_n,
   // Status line, open drain
   input  wire logic              status_i,
   output logic                   status_o,
   output logic                   status_oe,
   // Configuration done line, open drain
   input  wire logic              config_complete_i,
   output logic                   config_complete_o,
   output logic                   config_complete_oe,
   // Initialisation done line, open drain
   input  wire logic              init_done_i,
   output logic                   init_done_o,
   output logic                   init_done_oe,
   // Data pin driven as a user pin after configuration
   output logic                   data_pin_o,
   output logic                   data_pin_oe,
   // User logic side of the data pin
   input  wire logic              dual_purpose_io,
   input  wire logic              user_pin_o,
   input  wire logic              user_pin_oe,
   output logic                   user_pin_i,
   // Loaded configuration words
   output logic [WORD_W-1:0]      cfg_word,
   output logic                   cfg_word_valid,
   input  wire logic              cfg_word_ready,
   // Progress
   output logic                   user_mode,
   output logic                   load_error
);
   import psc_pkg::*;

   localparam int IDX_W = $clog2(WORD_W);

   // Link domain, rising edge of the serial clock
   typedef struct packed {
      logic [WORD_W-1:0] sh;
      logic [IDX_W-1:0]  idx;
      logic [31:0]       total;
      logic              done;
      logic [WORD_W-1:0] hold;
      logic              req;
      logic              ovr;
      logic              opt;
      logic              ack_s1;
      logic              ack_s2;
   } psc_lnk_s;

   // Link domain, falling edge of the serial clock
   typedef struct packed {
      logic [1:0] cnt;
   } psc_fe_s;

   // System domain; pin releases are stored so that zero means pulled low
   typedef struct packed {
      psc_state_e  st;
      logic [31:0] tmr;
      logic        req_s1;
      logic        req_s2;
      logic        done_s1;
      logic        done_s2;
      logic        fe_s1;
      logic        fe_s2;
      logic        opt_s1;
      logic        opt_s2;
      logic        ovr_s1;
      logic        ovr_s2;
      logic        tg_s1;
      logic        tg_s2;
      logic        tg_s3;
      logic        ud_s1;
      logic        ud_s2;
      logic        ack;
      logic        pend;
      logic        lnk_rst_n;
      logic        status_rel;
      logic        complete_rel;
      logic        init_pull;
      logic        dpin_o;
      logic        dpin_oe;
      logic        user;
      logic        err;
   } psc_sys_s;

   psc_lnk_s lnk_r;
   psc_lnk_s lnk_nxt;
   psc_fe_s  fe_r;
   psc_fe_s  fe_nxt;
   psc_sys_s sys_r;
   psc_sys_s sys_nxt;

   logic buf_in_ready;
   logic push;
   logic flush;

   // Status is pulled low while powering up, clearing or after an error
   function automatic logic status_free(input psc_state_e s);
      status_free = (s == ST_LOAD) || (s == ST_WAITFE) ||
                    (s == ST_INIT) || (s == ST_USER);
   endfunction : status_free

   // Done is released only once the whole bitstream is in
   function automatic logic complete_free(input psc_state_e s);
      complete_free = (s == ST_WAITFE) || (s == ST_INIT) || (s == ST_USER);
   endfunction : complete_free

   // ---------------- Link domain ----------------

   always_comb begin
      lnk_nxt        = lnk_r;
      lnk_nxt.ack_s1 = sys_r.ack;
      lnk_nxt.ack_s2 = lnk_r.ack_s1;
      // Once loaded, further data bits are ignored; only the ack synchroniser still moves on rising edges
      if (!lnk_r.done) begin
         lnk_nxt.sh[lnk_r.idx] = serial_config_data;
         if (lnk_r.total == 32'(OPT_BIT)) begin
            lnk_nxt.opt = serial_config_data;
         end
         if (lnk_r.idx == IDX_W'(WORD_W - 1)) begin
            lnk_nxt.idx = '0;
            // The host cannot be stalled, so a word still unacknowledged
            // when the next one completes is a load failure
            if (lnk_r.req != lnk_r.ack_s2) begin
               lnk_nxt.ovr = 1'b1;
            end else begin
               lnk_nxt.hold = lnk_nxt.sh;
               lnk_nxt.req  = ~lnk_r.req;
            end
         end else begin
            lnk_nxt.idx = lnk_r.idx + 1'b1;
         end
         lnk_nxt.total = lnk_r.total + 32'h1;
         if (lnk_r.total == 32'(CFG_BITS - 1)) begin
            lnk_nxt.done = 1'b1;
         end
      end
   end

   // Host stays quiet while this reset is asserted, so its release
   // cannot race a clock edge
   always_ff @(posedge serial_config_clock or negedge sys_r.lnk_rst_n) begin
      if (!sys_r.lnk_rst_n) begin
         lnk_r <= '0;
      end else begin
         lnk_r <= lnk_nxt;
      end
   end

   always_comb begin
      fe_nxt = fe_r;
      if (lnk_r.done && (fe_r.cnt != FE_LAST)) begin
         fe_nxt.cnt = fe_r.cnt + 2'h1;
      end
   end

   always_ff @(negedge serial_config_clock or negedge sys_r.lnk_rst_n) begin
      if (!sys_r.lnk_rst_n) begin
         fe_r <= '0;
      end else begin
         fe_r <= fe_nxt;
      end
   end

   // ---------------- System domain ----------------

   assign flush = (sys_r.st == ST_CLEAR);

   always_comb begin
      sys_nxt = sys_r;
      push    = 1'b0;
      // Synchronisers
      sys_nxt.req_s1  = config_request_n;
      sys_nxt.req_s2  = sys_r.req_s1;
      sys_nxt.done_s1 = lnk_r.done;
      sys_nxt.done_s2 = sys_r.done_s1;
      sys_nxt.fe_s1   = (fe_r.cnt == FE_LAST);
      sys_nxt.fe_s2   = sys_r.fe_s1;
      sys_nxt.opt_s1  = lnk_r.opt;
      sys_nxt.opt_s2  = sys_r.opt_s1;
      sys_nxt.ovr_s1  = lnk_r.ovr;
      sys_nxt.ovr_s2  = sys_r.ovr_s1;
      sys_nxt.tg_s1   = lnk_r.req;
      sys_nxt.tg_s2   = sys_r.tg_s1;
      sys_nxt.tg_s3   = sys_r.tg_s2;
      sys_nxt.ud_s1   = serial_config_data;
      sys_nxt.ud_s2   = sys_r.ud_s1;

      // Word handover: the ack is held back while the buffer is full
      if ((sys_r.pend || (sys_r.tg_s2 != sys_r.tg_s3)) && buf_in_ready) begin
         push         = 1'b1;
         sys_nxt.ack  = ~sys_r.ack;
         sys_nxt.pend = 1'b0;
      end else if (sys_r.tg_s2 != sys_r.tg_s3) begin
         sys_nxt.pend = 1'b1;
      end

      sys_nxt.tmr = sys_r.tmr + 32'h1;
      case (sys_r.st)
         ST_POR: begin
            if (sys_r.tmr == 32'(POR_CYC - 1)) begin
               sys_nxt.st  = ST_CLEAR;
               sys_nxt.tmr = TMR_RST;
            end
         end
         ST_CLEAR: begin
            sys_nxt.ack  = 1'b0;
            sys_nxt.pend = 1'b0;
            push         = 1'b0;
            if (sys_r.req_s2) begin
               sys_nxt.st = ST_LOAD;
            end
         end
         ST_LOAD: begin
            if (sys_r.ovr_s2) begin
               sys_nxt.st = ST_ERR;
            end else if (sys_r.done_s2) begin
               sys_nxt.st = ST_WAITFE;
            end
         end
         ST_WAITFE: begin
            sys_nxt.tmr = TMR_RST;
            if (sys_r.fe_s2) begin
               sys_nxt.st = ST_INIT;
            end
         end
         ST_INIT: begin
            if (sys_r.tmr == 32'(INIT_CYC - 1)) begin
               sys_nxt.st = ST_USER;
            end
         end
         ST_USER: begin
            sys_nxt.tmr = TMR_RST;
         end
         ST_ERR: begin
            sys_nxt.tmr = TMR_RST;
         end
         default: begin
            sys_nxt.st  = ST_POR;
            sys_nxt.tmr = TMR_RST;
         end
      endcase

      // A low request overrides everything but the power-on delay
      if (!sys_r.req_s2 && (sys_r.st != ST_POR)) begin
         sys_nxt.st  = ST_CLEAR;
         sys_nxt.tmr = TMR_RST;
      end

      // Pin levels follow the next state so they change with it
      sys_nxt.lnk_rst_n    = (sys_nxt.st != ST_CLEAR) &&
                             (sys_nxt.st != ST_POR);
      sys_nxt.status_rel   = status_free(sys_nxt.st);
      sys_nxt.complete_rel = complete_free(sys_nxt.st);
      sys_nxt.init_pull    = sys_r.opt_s2 && sys_nxt.lnk_rst_n &&
                             (sys_nxt.st != ST_USER) &&
                             (sys_nxt.st != ST_ERR);
      sys_nxt.user         = (sys_nxt.st == ST_USER);
      sys_nxt.err          = (sys_nxt.st == ST_ERR);
      sys_nxt.dpin_o       = user_pin_o;
      sys_nxt.dpin_oe      = (sys_nxt.st == ST_USER) && dual_purpose_io &&
                             user_pin_oe;
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         sys_r <= '0;
      end else begin
         sys_r <= sys_nxt;
      end
   end

   psc_buf2 #(
      .WIDTH (WORD_W),
      .DEPTH (BUF_DEPTH)
   ) u_buf (
      .clk_sys   (clk_sys),
      .rst_n     (rst_n),
      .flush     (flush),
      .in_valid  (push),
      .in_ready  (buf_in_ready),
      .in_data   (lnk_r.hold),
      .out_valid (cfg_word_valid),
      .out_ready (cfg_word_ready),
      .out_data  (cfg_word)
   );

   // Open-drain lines only ever pull low
   assign status_o           = 1'b0;
   assign status_oe          = ~sys_r.status_rel;
   assign config_complete_o  = 1'b0;
   assign config_complete_oe = ~sys_r.complete_rel;
   assign init_done_o        = 1'b0;
   assign init_done_oe       = sys_r.init_pull;
   assign data_pin_o         = sys_r.dpin_o;
   assign data_pin_oe        = sys_r.dpin_oe;
   assign user_pin_i         = sys_r.ud_s2;
   assign user_mode          = sys_r.user;
   assign load_error         = sys_r.err;

endmodule : psc_loader

// ==== dv/psc_loader_monitor.sv ====
// Port assertions for the serial configuration loader
module psc_loader_monitor #(
   parameter int POR_CYC = 20
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Pins and user side
   input wire logic config_request_n,
   input wire logic status_oe,
   input wire logic config_complete_oe,
   input wire logic init_done_oe,
   input wire logic data_pin_o,
   input wire logic data_pin_oe,
   input wire logic dual_purpose_io,
   input wire logic user_pin_o,
   input wire logic user_mode,
   input wire logic load_error
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [15:0] por_cnt_r;

   // Saturates so a long run never wraps back into the hold window
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) por_cnt_r <= 16'h0;
      else if (por_cnt_r < 16'(POR_CYC)) por_cnt_r <= por_cnt_r + 16'h1;
   end

   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   chk_user_lines_high: assert property (
      user_mode |-> !status_oe && !config_complete_oe)
      else $error("line pulled low in user mode");
   chk_request_restart: assert property (
      $fell(config_request_n) |->
      ##[1:6] (status_oe && config_complete_oe && !user_mode))
      else $error("request low did not restart");
   chk_por_status_hold: assert property (
      por_cnt_r < 16'(POR_CYC) |-> status_oe)
      else $error("status released inside reset delay");
   chk_done_after_por: assert property (
      $fell(config_complete_oe) |-> !status_oe)
      else $error("done released while status low");
   chk_error_keeps_done: assert property (
      load_error |-> config_complete_oe && status_oe)
      else $error("done released after a load error");
   chk_pin_needs_setting: assert property (
      data_pin_oe |-> $past(dual_purpose_io) && user_mode)
      else $error("data pin driven without user setting");
   chk_pin_follows_user: assert property (
      data_pin_oe |-> data_pin_o == $past(user_pin_o))
      else $error("data pin does not follow user logic");
   chk_init_low_busy: assert property (
      init_done_oe |-> !user_mode)
      else $error("init done pulled in user mode");
   chk_user_entry_clean: assert property (
      $rose(user_mode) |-> !init_done_oe && $past(!config_complete_oe))
      else $error("user mode entered unclean");
endmodule : psc_loader_monitor

bind psc_loader psc_loader_monitor #(.POR_CYC(POR_CYC)) u_mon (
   .clk_sys(clk_sys), .rst_n(rst_n), .config_request_n(config_request_n),
   .status_oe(status_oe), .config_complete_oe(config_complete_oe),
   .init_done_oe(init_done_oe), .data_pin_o(data_pin_o),
   .data_pin_oe(data_pin_oe), .dual_purpose_io(dual_purpose_io),
   .user_pin_o(user_pin_o), .user_mode(user_mode),
   .load_error(load_error)
);

// ==== dv/psc_host.sv ====
// Host model that drives the serial configuration link
module psc_host (
   // Link to the device
   output logic serial_config_clock,
   output logic serial_config_data,
   output logic config_request_n
);
   timeunit 1ns;
   timeprecision 1ps;

   // Clock parks low between frames, never floats
   initial begin
      serial_config_clock = 1'b0;
      serial_config_data  = 1'b0;
      config_request_n    = 1'b1;
   end

   // One bit a 32 ns period, LSB first, sampled on the rise
   task automatic send(input logic [31:0] bits, input int n);
      // Offset keeps link edges off the system clock edges
      #3;
      for (int i = 0; i < n; i++) begin
         serial_config_data = bits[i];
         #16 serial_config_clock = 1'b1;
         #16 serial_config_clock = 1'b0;
      end
      // Released data shows the inverse so a stale bit never matches
      serial_config_data = ~serial_config_data;
   endtask : send

   // Extra falling edges that start initialisation
   task automatic fall(input int n);
      #3;
      repeat (n) begin
         #16 serial_config_clock = 1'b1;
         #16 serial_config_clock = 1'b0;
      end
   endtask : fall

   // Data pin level seen by the device once it is a user pin
   task automatic put(input logic v);
      serial_config_data = v;
   endtask : put

   task automatic set_req(input logic v);
      config_request_n = v;
   endtask : set_req
endmodule : psc_host

// ==== dv/tb.sv ====
// Self-checking bench for the serial configuration loader
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import psc_pkg::*;

   localparam int POR_C = 20;
   localparam logic [31:0] STREAM = 32'h96c30f5a;
   logic       clk_sys = 1'b0;
   logic       rst_n = 1'b0;
   logic       scl, sda, req_n, st_oe, cd_oe, id_oe, dp_o, dp_oe;
   logic       up_i, ok_v, u_mode, l_err, st_o, cd_o, id_o;
   logic       dual = 1'b1, up_o = 1'b0, up_oe = 1'b0, rdy = 1'b0;
   logic [7:0] word;
   int         num_errors = 0;
   int         n_tests = 0;

   always #4 clk_sys = ~clk_sys;

   psc_host host (.serial_config_clock(scl), .serial_config_data(sda),
      .config_request_n(req_n));

   psc_loader #(.POR_CYC(POR_C), .INIT_CYC(8), .CFG_BITS(32), .OPT_BIT(3))
      DUT (
      .clk_sys(clk_sys), .rst_n(rst_n), .serial_config_clock(scl),
      .serial_config_data(sda), .config_request_n(req_n),
      .status_i(~st_oe), .status_o(st_o), .status_oe(st_oe),
      .config_complete_i(~cd_oe), .config_complete_o(cd_o),
      .config_complete_oe(cd_oe), .init_done_i(~id_oe), .init_done_o(id_o),
      .init_done_oe(id_oe), .data_pin_o(dp_o), .data_pin_oe(dp_oe),
      .dual_purpose_io(dual), .user_pin_o(up_o), .user_pin_oe(up_oe),
      .user_pin_i(up_i), .cfg_word(word), .cfg_word_valid(ok_v),
      .cfg_word_ready(rdy), .user_mode(u_mode), .load_error(l_err));

   task automatic chk1(input logic got, input logic exp);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk1

   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk8

   task automatic cyc(input int n);
      repeat (n) @(negedge clk_sys);
   endtask : cyc

   task automatic wait_for(ref logic s, input logic v);
      for (int i = 0; i < 40 && s !== v; i++) @(negedge clk_sys);
   endtask : wait_for

   // Pops one word with a single-cycle ready
   task automatic get_word(input logic [7:0] exp);
      wait_for(ok_v, 1'b1);
      chk8(word, exp);
      rdy = 1'b1;
      cyc(1);
      rdy = 1'b0;
   endtask : get_word

   task automatic t_por();
      repeat (POR_C) begin
         cyc(1);
         chk1(st_oe, 1'b1);
         chk1(cd_oe, 1'b1);
      end
      wait_for(st_oe, 1'b0);
      chk1(st_oe, 1'b0);
      // Open-drain lines may only ever pull low
      chk1(st_o, 1'b0);
      chk1(cd_o, 1'b0);
      chk1(id_o, 1'b0);
   endtask : t_por

   // Receiver stalls until both buffer entries hold a word
   task automatic t_load();
      for (int h = 0; h < 2; h++) begin
         host.send(STREAM >> (16 * h), 16);
         cyc(10);
         chk1(ok_v, 1'b1);
         chk1(l_err, 1'b0);
         if (h == 0) chk1(cd_oe, 1'b1);
         if (h == 0) chk1(id_oe, 1'b1);
         get_word(STREAM[16*h +: 8]);
         get_word(STREAM[16*h+8 +: 8]);
         cyc(2);
         chk1(ok_v, 1'b0);
      end
      wait_for(cd_oe, 1'b0);
      chk1(cd_oe, 1'b0);
      host.fall(1);
      cyc(10);
      chk1(u_mode, 1'b0);
      host.fall(1);
      wait_for(u_mode, 1'b1);
      chk1(u_mode, 1'b1);
      chk1(id_oe, 1'b0);
      chk1(st_oe, 1'b0);
      chk1(cd_oe, 1'b0);
   endtask : t_load

   task automatic t_user();
      up_oe = 1'b1;
      up_o = 1'b1;
      host.put(1'b1);
      cyc(4);
      chk1(dp_oe, 1'b1);
      chk1(dp_o, 1'b1);
      chk1(up_i, 1'b1);
      up_o = 1'b0;
      dual = 1'b0;
      host.put(1'b0);
      cyc(4);
      chk1(dp_oe, 1'b0);
      chk1(dp_o, 1'b0);
      chk1(up_i, 1'b0);
      dual = 1'b1;
   endtask : t_user

   task automatic t_restart();
      host.set_req(1'b0);
      cyc(8);
      chk1(st_oe, 1'b1);
      chk1(cd_oe, 1'b1);
      chk1(u_mode, 1'b0);
      host.set_req(1'b1);
      wait_for(st_oe, 1'b0);
      chk1(st_oe, 1'b0);
   endtask : t_restart

   // Third word waits in the hold stage behind a full, stalled buffer,
   // so the fourth one overruns; the buffered words must survive
   task automatic t_overrun();
      host.send(STREAM, 32);
      cyc(10);
      chk1(l_err, 1'b1);
      chk1(st_oe, 1'b1);
      chk1(cd_oe, 1'b1);
      get_word(STREAM[7:0]);
      get_word(STREAM[15:8]);
      host.fall(2);
      cyc(20);
      chk1(cd_oe, 1'b1);
      chk1(u_mode, 1'b0);
   endtask : t_overrun

   task automatic close_out();
      $display("checks %0d errors %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : close_out

   initial begin
      #50us;
      num_errors++;
      close_out();
   end

   initial begin
      cyc(12);
      rst_n = 1'b1;
      t_por();
      t_load();
      t_user();
      t_restart();
      t_overrun();
      close_out();
   end
endmodule : tb
